//--- include/iorc_defs.vh
// Constants for the I/O port reset and low-power control block.
// Operation
// - Reset holds every pin high-impedance analog.
// - Software picks pull-down or pull-up per port.
// - Nonvolatile setting loads automatically at reset release.
// - Low-power mode holds pins at present state.
// - Pin interrupt detection keeps running in low power.
// - Every pin sits in a boundary-scan chain.
// - I2C address wake only on one dedicated pin.
// - Per-pin edge select sets status, requests interrupt.
`ifndef IORC_DEFS_VH
`define IORC_DEFS_VH
`define IORC_NPIN 8
`define IORC_NV_SYNC_WAIT 2'h2
`define IORC_ADDR_CTRL 12'h000
`define IORC_ADDR_RSTCFG 12'h004
`define IORC_ADDR_DOUT 12'h008
`define IORC_ADDR_OE 12'h00C
`define IORC_ADDR_PIN 12'h010
`define IORC_ADDR_EDGE 12'h014
`define IORC_ADDR_STAT 12'h018
`define IORC_ADDR_MASK 12'h01C
`define IORC_ADDR_NVDATA 12'h020
`define IORC_ADDR_WAKE 12'h024
`define IORC_EDGE_NONE 2'h0
`define IORC_EDGE_RISE 2'h1
`define IORC_EDGE_FALL 2'h2
`define IORC_EDGE_BOTH 2'h3
`define IORC_CTRL_LP 0
`define IORC_CTRL_I2CW 1
`define IORC_DRV_HIZA 2'h0
`define IORC_DRV_PD 2'h1
`define IORC_DRV_PU 2'h2
`define IORC_DRV_STRONG 2'h3
`endif

//--- rtl/iorc_edge_detect.v
// Per-pin edge detector for the port interrupt unit.
`timescale 1ns/1ps
`include "iorc_defs.vh"
module iorc_edge_detect (
   input wire pclk,
   input wire presetn,
   input wire [7:0] pin_sync,
   input wire [15:0] edge_sel,
   output reg [7:0] evt
);
   reg [7:0] prev_q;
   reg [7:0] evt_d;
   integer i;
   always @* begin
      evt_d = 8'h00;
      for (i = 0; i < `IORC_NPIN; i = i + 1) begin
         case (edge_sel[2*i +: 2])
            `IORC_EDGE_RISE: evt_d[i] = pin_sync[i] & ~prev_q[i];
            `IORC_EDGE_FALL: evt_d[i] = ~pin_sync[i] & prev_q[i];
            `IORC_EDGE_BOTH: evt_d[i] = pin_sync[i] ^ prev_q[i];
            default: evt_d[i] = 1'b0;
         endcase
      end
   end
   // Runs regardless of low-power state so a pin can wake the part.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q <= 8'h00;
         evt <= 8'h00;
      end else begin
         prev_q <= pin_sync;
         evt <= evt_d;
      end
   end
endmodule // iorc_edge_detect

//--- rtl/iorc_bscan_cell.v
// Boundary-scan chain over the port pins.
`timescale 1ns/1ps
`include "iorc_defs.vh"
module iorc_bscan_cell (
   input wire pclk,
   input wire presetn,
   input wire scan_en,
   input wire scan_shift,
   input wire scan_update,
   input wire scan_in,
   input wire [7:0] pin_in,
   output wire scan_out,
   output reg [7:0] upd
);
   reg [7:0] sh_q;
   assign scan_out = sh_q[0];
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_q <= 8'h00;
         upd <= 8'h00;
      end else if (scan_en) begin
         if (scan_shift)
            sh_q <= {scan_in, sh_q[7:1]};
         else if (!scan_update)
            sh_q <= pin_in;
         if (scan_update)
            upd <= sh_q;
      end
   end
endmodule // iorc_bscan_cell

//--- rtl/iorc_port.v
// GPIO port with reset drive, low-power hold, pin interrupts and scan.
`timescale 1ns/1ps
`include "iorc_defs.vh"
module iorc_port (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [7:0] pin_i,
   output reg [7:0] pin_o,
   output reg [7:0] pin_oe_n,
   output reg [15:0] pin_drv,
   input wire nv_pull_up,
   input wire i2c_wake_pin_i,
   input wire scan_en,
   input wire scan_shift,
   input wire scan_update,
   input wire scan_in,
   output reg scan_out,
   output reg wake,
   output reg irq
);
   reg [7:0] p1_q, p2_q;
   reg w1_q, w2_q;
   reg nv1_q, nv2_q;
   reg [1:0] ctrl_q;
   reg rstcfg_q;
   reg nv_q;
   reg loaded_q;
   reg [1:0] nv_wait_q;
   reg [7:0] dout_q, oe_q;
   reg [15:0] edge_q;
   reg [7:0] stat_q, mask_q;
   reg [7:0] hold_o_q, hold_oe_q;
   reg wake_stat_q;
   wire [7:0] evt;
   wire [7:0] upd;
   wire chain_out;
   wire acc, wr, rd;
   wire lp;
   assign acc = psel & penable;
   assign wr = acc & pwrite & loaded_q;
   assign rd = acc & ~pwrite;
   assign lp = ctrl_q[`IORC_CTRL_LP];

   function hit;
      input [11:0] a;
      input [11:0] r;
      begin
         hit = (a == r);
      end
   endfunction

   iorc_edge_detect u_edge (
      .pclk(pclk),
      .presetn(presetn),
      .pin_sync(p2_q),
      .edge_sel(edge_q),
      .evt(evt)
   );

   iorc_bscan_cell u_scan (
      .pclk(pclk),
      .presetn(presetn),
      .scan_en(scan_en),
      .scan_shift(scan_shift),
      .scan_update(scan_update),
      .scan_in(scan_in),
      .pin_in(p2_q),
      .scan_out(chain_out),
      .upd(upd)
   );

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         p1_q <= 8'h00;
         p2_q <= 8'h00;
         w1_q <= 1'b0;
         w2_q <= 1'b0;
         nv1_q <= 1'b0;
         nv2_q <= 1'b0;
      end else begin
         p1_q <= pin_i;
         p2_q <= p1_q;
         w1_q <= i2c_wake_pin_i;
         w2_q <= w1_q;
         nv1_q <= nv_pull_up;
         nv2_q <= nv1_q;
      end
   end

   // The nonvolatile copy lands once, after the strap has passed both
   // synchroniser stages; sooner, it would copy their reset value.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loaded_q <= 1'b0;
         rstcfg_q <= 1'b0;
         nv_q <= 1'b0;
         nv_wait_q <= 2'h0;
      end else if (!loaded_q) begin
         if (nv_wait_q == `IORC_NV_SYNC_WAIT) begin
            nv_q <= nv2_q;
            rstcfg_q <= nv2_q;
            loaded_q <= 1'b1;
         end else begin
            nv_wait_q <= nv_wait_q + 2'h1;
         end
      end else if (wr && hit(paddr, `IORC_ADDR_NVDATA)) begin
         nv_q <= pwdata[0];
      end else if (wr && hit(paddr, `IORC_ADDR_RSTCFG)) begin
         rstcfg_q <= pwdata[0];
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= 2'h0;
         dout_q <= 8'h00;
         oe_q <= 8'h00;
         edge_q <= 16'h0000;
         mask_q <= 8'h00;
      end else if (wr) begin
         if (hit(paddr, `IORC_ADDR_CTRL))
            ctrl_q <= pwdata[1:0];
         if (hit(paddr, `IORC_ADDR_DOUT))
            dout_q <= pwdata[7:0];
         if (hit(paddr, `IORC_ADDR_OE))
            oe_q <= pwdata[7:0];
         if (hit(paddr, `IORC_ADDR_EDGE))
            edge_q <= pwdata[15:0];
         if (hit(paddr, `IORC_ADDR_MASK))
            mask_q <= pwdata[7:0];
      end else if (lp && (|(stat_q & mask_q) || wake_stat_q)) begin
         ctrl_q[`IORC_CTRL_LP] <= 1'b0;
      end
   end

   // Sticky status; a read clears only the bits that it returned, so an
   // event in the setup cycle survives, and a new event wins over a clear.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= 8'h00;
         wake_stat_q <= 1'b0;
      end else begin
         if (rd && hit(paddr, `IORC_ADDR_STAT))
            stat_q <= (stat_q & ~prdata[7:0]) | evt;
         else
            stat_q <= stat_q | evt;
         if (rd && hit(paddr, `IORC_ADDR_WAKE))
            wake_stat_q <= (wake_stat_q & ~prdata[0]) |
               (lp & ctrl_q[`IORC_CTRL_I2CW] & w2_q);
         else if (lp && ctrl_q[`IORC_CTRL_I2CW] && w2_q)
            wake_stat_q <= 1'b1;
      end
   end

   // Pin state is frozen while in low power.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_o_q <= 8'h00;
         hold_oe_q <= 8'h00;
      end else if (!lp) begin
         hold_o_q <= dout_q;
         hold_oe_q <= oe_q;
      end
   end

   integer k;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_o <= 8'h00;
         pin_oe_n <= 8'hFF;
         pin_drv <= 16'h0000;
      end else if (!loaded_q) begin
         // Pins stay in the reset state until the reset drive is in place.
         pin_o <= 8'h00;
         pin_oe_n <= 8'hFF;
         pin_drv <= {8{`IORC_DRV_HIZA}};
      end else if (scan_en) begin
         pin_o <= upd;
         pin_oe_n <= 8'h00;
         pin_drv <= {8{`IORC_DRV_STRONG}};
      end else begin
         pin_o <= hold_o_q;
         pin_oe_n <= ~hold_oe_q;
         for (k = 0; k < `IORC_NPIN; k = k + 1) begin
            if (hold_oe_q[k])
               pin_drv[2*k +: 2] <= `IORC_DRV_STRONG;
            else if (rstcfg_q)
               pin_drv[2*k +: 2] <= `IORC_DRV_PU;
            else
               pin_drv[2*k +: 2] <= `IORC_DRV_PD;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
         wake <= 1'b0;
         scan_out <= 1'b0;
      end else begin
         irq <= |(stat_q & mask_q);
         wake <= lp & (|(stat_q & mask_q) | wake_stat_q);
         scan_out <= chain_out;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               `IORC_ADDR_CTRL: prdata <= {30'h0, ctrl_q};
               `IORC_ADDR_RSTCFG: prdata <= {31'h0, rstcfg_q};
               `IORC_ADDR_DOUT: prdata <= {24'h0, dout_q};
               `IORC_ADDR_OE: prdata <= {24'h0, oe_q};
               `IORC_ADDR_PIN: prdata <= {24'h0, p2_q};
               `IORC_ADDR_EDGE: prdata <= {16'h0, edge_q};
               `IORC_ADDR_STAT: prdata <= {24'h0, stat_q};
               `IORC_ADDR_MASK: prdata <= {24'h0, mask_q};
               `IORC_ADDR_NVDATA: prdata <= {31'h0, nv_q};
               `IORC_ADDR_WAKE: prdata <= {31'h0, wake_stat_q};
               default: pslverr <= 1'b1;
            endcase
         end else if (psel && !penable) begin
            case (paddr)
               `IORC_ADDR_CTRL, `IORC_ADDR_RSTCFG, `IORC_ADDR_DOUT,
               `IORC_ADDR_OE, `IORC_ADDR_PIN, `IORC_ADDR_EDGE,
               `IORC_ADDR_STAT, `IORC_ADDR_MASK, `IORC_ADDR_NVDATA,
               `IORC_ADDR_WAKE: pslverr <= 1'b0;
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end
endmodule // iorc_port

//--- verification/iorc_port_monitor.sv
// Assertion checker on the GPIO port block's ports.
`timescale 1ns/1ps
module iorc_port_monitor (
   input logic pclk,
   input logic presetn,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [11:0] paddr,
   input logic [31:0] prdata,
   input logic pready,
   input logic pslverr,
   input logic [7:0] pin_oe_n,
   input logic [15:0] pin_drv,
   input logic nv_pull_up,
   input logic scan_en,
   input logic irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup; psel && !penable; endsequence
   sequence s_access; psel && penable && pready; endsequence
   property p_rst_hiz;
      disable iff (1'h0) !presetn |-> pin_oe_n == 8'hFF && pin_drv == 16'h0;
   endproperty
   property p_ready; s_setup |=> s_access; endproperty
   property p_one; pready |=> !pready; endproperty
   property p_err;
      pready |-> pslverr == (paddr > 12'h024 || paddr[1:0] != 2'h0);
   endproperty
   property p_err_data; pready && pslverr && !pwrite |-> prdata == 32'h0;
   endproperty
   property p_nv; $rose(presetn) && !scan_en |-> ##4
      pin_drv == (nv_pull_up ? 16'hAAAA : 16'h5555);
   endproperty
   property p_scan; scan_en [*2] |=> pin_oe_n == 8'h0 && pin_drv == 16'hFFFF;
   endproperty
   property p_irq_fall; $fell(irq) |-> $past(pready) || $past(pready, 2);
   endproperty
   a_rst_hiz: assert property (p_rst_hiz) else $error("pins not hi-z");
   a_ready: assert property (p_ready) else $error("no ready");
   a_one: assert property (p_one) else $error("long ready");
   a_err: assert property (p_err) else $error("bad slverr");
   a_err_data: assert property (p_err_data) else $error("bad err data");
   a_nv: assert property (p_nv) else $error("reset drive not loaded");
   a_scan: assert property (p_scan) else $error("scan no drive");
   a_irq_fall: assert property (p_irq_fall) else $error("irq lost");
endmodule // iorc_port_monitor

//--- verification/iorc_pin_model.sv
// Board-side pin model: external drivers meet the port's own outputs.
`timescale 1ns/1ps
module iorc_pin_model (
   input wire [7:0] pin_o,
   input wire [7:0] pin_oe_n,
   input wire [7:0] ext,
   output wire [7:0] pin_i
);
   // A pin whose driver is enabled shows the port's value, else the board's.
   assign pin_i = (~pin_oe_n & pin_o) | (pin_oe_n & ext);
endmodule // iorc_pin_model

//--- verification/iorc_port_tb.sv
// Self-checking bench for the GPIO port block.
`timescale 1ns/1ps
`include "iorc_defs.vh"
module iorc_port_tb;
   reg pclk = 1'h0;
   reg presetn = 1'h1;
   reg psel = 1'h0;
   reg penable = 1'h0;
   reg pwrite = 1'h0;
   reg [11:0] paddr = 12'h0;
   reg [31:0] pwdata = 32'h0;
   reg [7:0] ext = 8'h0;
   reg nv_pull_up = 1'h1;
   reg i2c_wake_pin_i = 1'h0;
   reg scan_en = 1'h0;
   reg scan_shift = 1'h0;
   reg scan_update = 1'h0;
   reg scan_in = 1'h0;
   localparam [7:0] scan_pat = 8'hA5;
   reg err;
   reg [31:0] r;
   wire [31:0] prdata;
   wire pready, pslverr, scan_out, wake, irq;
   wire [7:0] pin_i, pin_o, pin_oe_n;
   wire [15:0] pin_drv;
   integer n_fail = 0;
   integer checks_done = 0;
   integer k;
   always #50 pclk = ~pclk;
   iorc_port u_iorc_port (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_i(pin_i),
      .pin_o(pin_o), .pin_oe_n(pin_oe_n), .pin_drv(pin_drv),
      .nv_pull_up(nv_pull_up), .i2c_wake_pin_i(i2c_wake_pin_i),
      .scan_en(scan_en), .scan_shift(scan_shift),
      .scan_update(scan_update), .scan_in(scan_in),
      .scan_out(scan_out), .wake(wake), .irq(irq));
   iorc_pin_model u_iorc_pin_model (.pin_o(pin_o), .pin_oe_n(pin_oe_n),
      .ext(ext), .pin_i(pin_i));
   task stop_test;
      begin
         $display("checks %0d mismatches %0d", checks_done, n_fail);
         if (n_fail == 0 && checks_done > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task chk(input string s, input [31:0] e, input [31:0] g);
      begin
         checks_done = checks_done + 1;
         if (g !== e) begin
            $display("ERROR %s expected %h seen %h", s, e, g);
            n_fail = n_fail + 1;
         end
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge pclk);
         psel <= 1'h1;
         penable <= 1'h0;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'h1;
         @(posedge pclk);
         for (k = 0; k < 20 && pready !== 1'h1; k = k + 1)
            @(posedge pclk);
         chk("pready", 32'h1, {31'h0, pready});
         if (pready !== 1'h1)
            stop_test;
         r = prdata;
         err = pslverr;
         psel <= 1'h0;
         penable <= 1'h0;
      end
   endtask
   task wait_wake;
      begin
         for (k = 0; k < 20 && wake !== 1'h1; k = k + 1)
            @(posedge pclk);
         chk("wake", 32'h1, {31'h0, wake});
         if (wake !== 1'h1)
            stop_test;
      end
   endtask
   initial begin
      presetn <= 1'h0;
      repeat (5) @(posedge pclk);
      chk("rst_oe_n", 32'hFF, pin_oe_n);
      chk("rst_drv", 32'h0, pin_drv);
      presetn <= 1'h1;
      apb(1'h1, `IORC_ADDR_RSTCFG, 32'h0);
      repeat (2) @(posedge pclk);
      chk("nv_drv", 32'hAAAA, pin_drv);
      apb(1'h0, `IORC_ADDR_RSTCFG, 32'h0);
      chk("rstcfg", 32'h1, r);
      apb(1'h1, `IORC_ADDR_RSTCFG, 32'h0);
      repeat (2) @(posedge pclk);
      chk("pd_drv", 32'h5555, pin_drv);
      apb(1'h0, 12'h028, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      apb(1'h1, `IORC_ADDR_EDGE, 32'h39);
      apb(1'h1, `IORC_ADDR_MASK, 32'hFF);
      ext <= 8'h0F;
      repeat (6) @(posedge pclk);
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'h0, `IORC_ADDR_STAT, 32'h0);
      chk("stat_rise", 32'h05, r);
      ext <= 8'h00;
      repeat (6) @(posedge pclk);
      apb(1'h0, `IORC_ADDR_STAT, 32'h0);
      chk("stat_fall", 32'h06, r);
      repeat (2) @(posedge pclk);
      chk("irq_clr", 32'h0, {31'h0, irq});
      apb(1'h1, `IORC_ADDR_OE, 32'h01);
      apb(1'h1, `IORC_ADDR_DOUT, 32'h01);
      repeat (6) @(posedge pclk);
      apb(1'h0, `IORC_ADDR_STAT, 32'h0);
      apb(1'h1, `IORC_ADDR_CTRL, 32'h01);
      apb(1'h1, `IORC_ADDR_DOUT, 32'h00);
      repeat (2) @(posedge pclk);
      chk("lp_hold", 32'h01, pin_o);
      ext <= 8'h04;
      wait_wake;
      repeat (3) @(posedge pclk);
      chk("lp_exit", 32'h0, pin_o);
      apb(1'h0, `IORC_ADDR_STAT, 32'h0);
      apb(1'h1, `IORC_ADDR_CTRL, 32'h03);
      repeat (2) @(posedge pclk);
      chk("idle_wake", 32'h0, {31'h0, wake});
      i2c_wake_pin_i <= 1'h1;
      wait_wake;
      i2c_wake_pin_i <= 1'h0;
      apb(1'h0, `IORC_ADDR_WAKE, 32'h0);
      chk("i2c_stat", 32'h1, r);
      scan_en <= 1'h1;
      repeat (3) @(posedge pclk);
      chk("scan_oe_n", 32'h0, pin_oe_n);
      for (k = 0; k < 8; k = k + 1) begin
         scan_shift <= 1'h1;
         scan_in <= scan_pat[k];
         @(posedge pclk);
      end
      scan_shift <= 1'h0;
      scan_update <= 1'h1;
      @(posedge pclk);
      scan_update <= 1'h0;
      repeat (2) @(posedge pclk);
      chk("scan_pin_o", {24'h0, scan_pat}, {24'h0, pin_o});
      repeat (2) @(posedge pclk);
      scan_shift <= 1'h1;
      @(posedge pclk);
      for (k = 0; k < 8; k = k + 1) begin
         @(posedge pclk);
         chk("scan_out", {31'h0, scan_pat[k]}, {31'h0, scan_out});
      end
      scan_shift <= 1'h0;
      presetn <= 1'h0;
      scan_en <= 1'h0;
      @(posedge pclk);
      chk("rst2_drv", 32'h0, pin_drv);
      stop_test;
   end
endmodule // iorc_port_tb
bind iorc_port iorc_port_monitor u_iorc_port_monitor (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pin_oe_n(pin_oe_n), .pin_drv(pin_drv), .nv_pull_up(nv_pull_up),
   .scan_en(scan_en), .irq(irq));
